// ### hdl/prs_pkg.sv
// Package of constants and carrier types for the return-address stack
package prs_pkg;
   localparam int PC_WIDTH = 11;
   localparam int PTR_WIDTH = 3;
   localparam int DEPTH = 8;
   localparam int ADDR_WIDTH = 8;
   localparam logic [7:0] ADDR_STACK_POINTER = 8'hdf;
   localparam logic [7:0] ADDR_ENTRY_BASE = 8'hf0;
   localparam logic [7:0] ADDR_ENTRY_LAST = 8'hff;
   localparam int GIE_BIT = 7;
   localparam logic [2:0] PTR_RESET = 3'h7;
   localparam logic GIE_RESET = 1'b0;
   localparam logic [10:0] PC_RESET = 11'h000;
   localparam logic [10:0] ENTRY_RESET = 11'h000;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } prs_bus_req_type;

   typedef struct packed {
      logic push;
      logic pop;
      logic [10:0] pc;
   } prs_seq_req_type;
endpackage : prs_pkg

// ### hdl/prs_entry.sv
// One stack level: an 11-bit saved program counter
`timescale 1ns/1ps
module prs_entry (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic load_i,
   input wire logic [10:0] data_i,
   input wire logic wr_high_i,
   input wire logic wr_low_i,
   input wire logic [7:0] wdata_i,
   output logic [10:0] value_o
);
   import prs_pkg::*;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         value_o <= ENTRY_RESET;
      end else if (load_i) begin
         value_o <= data_i;
      end else begin
         // High byte keeps only three bits
         if (wr_high_i) begin
            value_o[10:8] <= wdata_i[2:0];
         end
         if (wr_low_i) begin
            value_o[7:0] <= wdata_i;
         end
      end
   end
endmodule : prs_entry

// ### hdl/prs_rdmux.sv
// Register read multiplexer over pointer and entry bytes
`timescale 1ns/1ps
module prs_rdmux (
   input wire logic [7:0] addr_i,
   input wire logic [2:0] ptr_i,
   input wire logic gie_i,
   input wire logic [10:0] entry_i [8],
   output logic [7:0] data_o
);
   import prs_pkg::*;
   logic [2:0] idx;
   always_comb begin
      idx = addr_i[3:1];
      data_o = 8'h00;
      if (addr_i == ADDR_STACK_POINTER) begin
         data_o = {gie_i, 4'h0, ptr_i};
      end else if (addr_i >= ADDR_ENTRY_BASE) begin
         if (addr_i[0]) begin
            data_o = {5'h00, entry_i[idx][10:8]};
         end else begin
            data_o = entry_i[idx][7:0];
         end
      end
   end
endmodule : prs_rdmux

// ### hdl/prs_stack.sv
// Top of the return-address stack with pointer, entries and program counter
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module prs_stack (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire prs_pkg::prs_bus_req_type bus_i,
   input wire prs_pkg::prs_seq_req_type seq_i,
   output logic [7:0] rdata_o,
   output logic [10:0] program_counter_o,
   output logic global_interrupt_enable_o,
   output logic [2:0] stack_level_index_o,
   output logic overflow_o
);
   import prs_pkg::*;

   logic [2:0] ptr;
   logic global_interrupt_enable;
   logic [10:0] pc;
   logic [10:0] entries [8];
   logic [2:0] push_slot;
   logic [2:0] pop_slot;
   logic [7:0] next_rdata;
   logic ptr_wr;
   logic entry_wr;
   logic [2:0] wr_idx;
   logic push;
   logic pop;

   // Push and pop at once is meaningless; push wins
   assign push = seq_i.push;
   assign pop = seq_i.pop & ~seq_i.push;

   // Entry written by a push: pointer 111 -> 0, 110 -> 1 ... 000 -> 7 wraps back
   // The new pointer p designates entry (6 - p) mod 8
   assign push_slot = 3'(3'h6 - (ptr - 3'h1));
   assign pop_slot = 3'(3'h6 - ptr);

   assign ptr_wr = bus_i.wr && (bus_i.addr == ADDR_STACK_POINTER);
   assign entry_wr = bus_i.wr && (bus_i.addr >= ADDR_ENTRY_BASE);
   assign wr_idx = bus_i.addr[3:1];

   // Pointer: hardware push/pop beats a software write in the same cycle
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ptr <= PTR_RESET;
      end else if (push) begin
         ptr <= ptr - 3'h1;
      end else if (pop) begin
         ptr <= ptr + 3'h1;
      end else if (ptr_wr) begin
         ptr <= bus_i.wdata[2:0];
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         global_interrupt_enable <= GIE_RESET;
      end else if (ptr_wr) begin
         global_interrupt_enable <= bus_i.wdata[GIE_BIT];
      end
   end

   // Program counter restored on return, otherwise taken from the sequencer
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pc <= PC_RESET;
      end else if (pop) begin
         pc <= entries[pop_slot];
      end else begin
         pc <= seq_i.pc;
      end
   end

   // Overflow: a push from pointer 111 while entry 7 is in use
   logic full;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         full <= 1'b0;
      end else if (push) begin
         full <= (ptr == 3'h0);
      end else if (pop || ptr_wr) begin
         full <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         overflow_o <= 1'b0;
      end else begin
         overflow_o <= push && full;
      end
   end

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_level
         prs_entry u_entry (
            .mclk_i(mclk_i),
            .rst_n_i(rst_n_i),
            .load_i(push && (push_slot == 3'(g))),
            .data_i(seq_i.pc),
            .wr_high_i(entry_wr && (wr_idx == 3'(g)) && bus_i.addr[0]),
            .wr_low_i(entry_wr && (wr_idx == 3'(g)) && !bus_i.addr[0]),
            .wdata_i(bus_i.wdata),
            .value_o(entries[g])
         );
      end
   endgenerate

   prs_rdmux u_rdmux (
      .addr_i(bus_i.addr),
      .ptr_i(ptr),
      .gie_i(global_interrupt_enable),
      .entry_i(entries),
      .data_o(next_rdata)
   );

   // Read data only in the cycle after the strobe
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (bus_i.rd) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= 8'h00;
      end
   end

   assign program_counter_o = pc;
   assign global_interrupt_enable_o = global_interrupt_enable;
   assign stack_level_index_o = ptr;

   property p_push_dec;
      @(posedge mclk_i) disable iff (!rst_n_i)
      push |=> ptr == $past(ptr) - 3'h1;
   endproperty
   a_push_dec: assert property (p_push_dec) else $error("push did not decrement");

   property p_pop_inc;
      @(posedge mclk_i) disable iff (!rst_n_i)
      pop |=> ptr == $past(ptr) + 3'h1;
   endproperty
   a_pop_inc: assert property (p_pop_inc) else $error("pop did not increment");

   sequence s_push_then_pop;
      push ##1 pop;
   endsequence
   property p_lifo;
      logic [10:0] v;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (push, v = seq_i.pc) ##1 pop |=> pc == v;
   endproperty
   a_lifo: assert property (p_lifo) else $error("pop lost last pushed pc");

   property p_first_slot;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (push && ptr == 3'h7 && !full) |=> entries[0] == $past(seq_i.pc);
   endproperty
   a_first_slot: assert property (p_first_slot) else $error("first push not in entry 0");

   property p_pop_restore;
      @(posedge mclk_i) disable iff (!rst_n_i)
      pop |=> pc == $past(entries[pop_slot]);
   endproperty
   a_pop_restore: assert property (p_pop_restore) else $error("pop pc wrong");

   property p_gie_write;
      @(posedge mclk_i) disable iff (!rst_n_i)
      ptr_wr |=> global_interrupt_enable == $past(bus_i.wdata[GIE_BIT]);
   endproperty
   a_gie_write: assert property (p_gie_write) else $error("gie write lost");

   property p_ptr_write;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (ptr_wr && !push && !pop) |=> ptr == $past(bus_i.wdata[2:0]);
   endproperty
   a_ptr_write: assert property (p_ptr_write) else $error("pointer write lost");

   property p_reserved_zero;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (bus_i.rd && bus_i.addr == ADDR_STACK_POINTER) |=> rdata_o[6:3] == 4'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

   property p_idle_rdata;
      @(posedge mclk_i) disable iff (!rst_n_i)
      !bus_i.rd |=> rdata_o == 8'h00;
   endproperty
   a_idle_rdata: assert property (p_idle_rdata) else $error("rdata outside read");

   // A push then a pop must leave the pointer where it started
   property p_push_pop_ptr;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_push_then_pop |=> ptr == $past(ptr, 2);
   endproperty
   a_push_pop_ptr: assert property (p_push_pop_ptr) else $error("push pop pointer");

   property p_push_load;
      @(posedge mclk_i) disable iff (!rst_n_i)
      push |=> entries[$past(push_slot)] == $past(seq_i.pc);
   endproperty
   a_push_load: assert property (p_push_load) else $error("push did not save pc");

   property p_full_set;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (push && ptr == 3'h0) |=> full;
   endproperty
   a_full_set: assert property (p_full_set) else $error("eighth push not full");

   property p_overflow;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (push && full) |=> overflow_o;
   endproperty
   a_overflow: assert property (p_overflow) else $error("ninth push no overflow");

   property p_no_false_ovf;
      @(posedge mclk_i) disable iff (!rst_n_i)
      !(push && full) |=> !overflow_o;
   endproperty
   a_no_false_ovf: assert property (p_no_false_ovf) else $error("spurious overflow");

   property p_pc_follow;
      @(posedge mclk_i) disable iff (!rst_n_i)
      !pop |=> pc == $past(seq_i.pc);
   endproperty
   a_pc_follow: assert property (p_pc_follow) else $error("pc not following");

   property p_ptr_hold;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (!push && !pop && !ptr_wr) |=> $stable(ptr);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved idle");

   property p_gie_hold;
      @(posedge mclk_i) disable iff (!rst_n_i)
      !ptr_wr |=> $stable(global_interrupt_enable);
   endproperty
   a_gie_hold: assert property (p_gie_hold) else $error("gie moved idle");

   property p_rd_ptr;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (bus_i.rd && bus_i.addr == ADDR_STACK_POINTER) |=> rdata_o[2:0] == $past(ptr);
   endproperty
   a_rd_ptr: assert property (p_rd_ptr) else $error("pointer read wrong");

   property p_rd_unmapped;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (bus_i.rd && bus_i.addr != ADDR_STACK_POINTER && bus_i.addr < ADDR_ENTRY_BASE)
         |=> rdata_o == 8'h00;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");

   property p_entry_high_zero;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (bus_i.rd && bus_i.addr >= ADDR_ENTRY_BASE && bus_i.addr[0]) |=> rdata_o[7:3] == 5'h00;
   endproperty
   a_entry_high_zero: assert property (p_entry_high_zero) else $error("high byte bits");
endmodule : prs_stack

// ### tb/prs_seq_model.sv
// Sequencer model issuing calls and returns to the stack
`timescale 1ns/1ps
module prs_seq_model
   import prs_pkg::*;
(
   input wire logic mclk_i,
   output prs_seq_req_type seq_o
);
   initial seq_o = '0;

   // Pc stays driven between calls, as the real counter never floats
   task automatic call(input logic [10:0] pc);
      @(posedge mclk_i);
      seq_o.pc <= pc;
      seq_o.push <= 1'b1;
      @(posedge mclk_i);
      seq_o.push <= 1'b0;
   endtask : call

   task automatic ret();
      @(posedge mclk_i);
      seq_o.pop <= 1'b1;
      @(posedge mclk_i);
      seq_o.pop <= 1'b0;
   endtask : ret
endmodule : prs_seq_model

// ### tb/test_prs_stack.sv
// Testbench for the return-address stack
`timescale 1ns/1ps
module test_prs_stack;
   import prs_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   prs_bus_req_type bus = '0;
   prs_seq_req_type seq;
   logic [7:0] rdata;
   logic [10:0] pc;
   logic global_interrupt_enable;
   logic [2:0] ptr;
   logic ovf;
   int error_cnt = 0;
   int n_checks = 0;

   always #10 mclk_i = ~mclk_i;

   prs_seq_model u_seq (.mclk_i(mclk_i), .seq_o(seq));
   prs_stack u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus), .seq_i(seq),
      .rdata_o(rdata), .program_counter_o(pc), .global_interrupt_enable_o(global_interrupt_enable),
      .stack_level_index_o(ptr), .overflow_o(ovf));

   function automatic logic [10:0] pcv(input int k);
      return 11'(k * 179 + 5);
   endfunction : pcv

   task automatic print_verdict();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input logic [10:0] seen, input logic [10:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge mclk_i);
      bus.wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [10:0] exp);
      @(posedge mclk_i);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge mclk_i);
      bus.rd <= 1'b0;
      #1;
      check({3'h0, rdata}, exp);
   endtask : rdchk

   initial begin
      logic [10:0] e;
      repeat (16) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      #1;
      check(pc, PC_RESET);
      check({7'h0, global_interrupt_enable, ptr}, 11'h007);
      rdchk(ADDR_STACK_POINTER, 11'h007);
      for (int i = 0; i < 16; i++) begin
         rdchk(ADDR_ENTRY_BASE + 8'(i), 11'h000);
      end
      wr(ADDR_STACK_POINTER, 8'hfa);
      rdchk(ADDR_STACK_POINTER, 11'h082);
      #1;
      check({10'h0, global_interrupt_enable}, 11'h001);
      wr(ADDR_STACK_POINTER, 8'h07);
      wr(8'he0, 8'h55);
      rdchk(8'he0, 11'h000);
      for (int k = 1; k < 10; k++) begin
         u_seq.call(pcv(k));
         #1;
         check({8'h0, ptr}, {8'h0, 3'(7 - k)});
         check({10'h0, ovf}, 11'(k == 9));
      end
      // Ninth push wrapped onto entry 0
      for (int i = 0; i < 8; i++) begin
         e = (i == 0) ? pcv(9) : pcv(i + 1);
         rdchk(ADDR_ENTRY_BASE + 8'(2 * i), {3'h0, e[7:0]});
         rdchk(ADDR_ENTRY_BASE + 8'(2 * i + 1), {8'h0, e[10:8]});
      end
      wr(8'hf3, 8'hfe);
      rdchk(8'hf3, 11'h006);
      for (int j = 0; j < 8; j++) begin
         e = pcv(9 - j);
         if (j == 7) begin
            e[10:8] = 3'h6;
         end
         u_seq.ret();
         #1;
         check(pc, e);
         check({8'h0, ptr}, {8'h0, 3'(7 + j)});
      end
      // Push and pointer write in one cycle: push moves pointer, gie still taken
      fork
         u_seq.call(pcv(3));
         wr(ADDR_STACK_POINTER, 8'h83);
      join
      #1;
      check({8'h0, ptr}, 11'h005);
      check({10'h0, global_interrupt_enable}, 11'h001);
      u_seq.ret();
      #1;
      check(pc, pcv(3));
      check({8'h0, ptr}, 11'h006);
      // Reset again in mid-run
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      #1;
      check(pc, PC_RESET);
      check({7'h0, global_interrupt_enable, ptr}, 11'h007);
      rdchk(ADDR_ENTRY_BASE + 8'h02, 11'h000);
      print_verdict();
   end

   initial begin
      #200000;
      error_cnt++;
      print_verdict();
   end
endmodule : test_prs_stack
